// ---- sispce_regs.vh ----
// register offsets, field positions, opcodes and timing constants of the isp host
`ifndef SISPCE_REGS_VH
`define SISPCE_REGS_VH

`define SISPCE_ADDR_W 4
`define SISPCE_OFS_CTRL 4'h0
`define SISPCE_OFS_INSTR 4'h1
`define SISPCE_OFS_RESP 4'h2
`define SISPCE_OFS_STAT 4'h3

`define SISPCE_CTRL_START 0
`define SISPCE_CTRL_END 1
`define SISPCE_CTRL_POLL 2
`define SISPCE_CTRL_GO 3

`define SISPCE_STAT_BUSY 0
`define SISPCE_STAT_SESS 1
`define SISPCE_STAT_FAIL 2
`define SISPCE_STAT_REFUSED 3
`define SISPCE_STAT_DONE 4

`define SISPCE_INSTR_ENABLE 32'hAC53_0000
`define SISPCE_INSTR_POLL 32'hF000_0000
`define SISPCE_ECHO 8'h53
`define SISPCE_OP_AC 8'hAC
`define SISPCE_SUB_ERASE 8'h80
`define SISPCE_SUB_LOCK 8'hE0
`define SISPCE_SUB_FUSE_LO 8'hA0
`define SISPCE_SUB_FUSE_HI 8'hA8
`define SISPCE_SUB_FUSE_EXT 8'hA4
`define SISPCE_OP_LOAD_LO 8'h40
`define SISPCE_OP_LOAD_HI 8'h48
`define SISPCE_OP_PAGE_WR 8'h4C
`define SISPCE_OP_EE_WR 8'hC0
`define SISPCE_OP_EE_PAGE_WR 8'hC2

`define SISPCE_CLK_MHZ 200
`define SISPCE_T_PWRUP_US 20000
`define SISPCE_T_ERASE_US 9000
`define SISPCE_T_FLASH_US 4500
`define SISPCE_T_EEPROM_US 4000
`define SISPCE_T_FUSE_US 4500
`define SISPCE_T_RST_PULSE_NS 2500
`define SISPCE_T_SCK_HALF_NS 500
`define SISPCE_MAX_RETRY 4

`endif

// ---- sispce_host.v ----
// serial isp host: session control, instruction shifter, wait and poll sequencing
// Functional notes
// - programming link used only while device reset pin is held low
// - instructions refused by host until programming enable was accepted
// - always shift four bytes; on missing echo pulse reset and retry
// - sck low and high phases each last a long programmable half period
// - power-up holds reset and sck low, then a reset pulse high
// - wait 20 ms after power-up sequence before programming enable
// - chip erase followed by 9.0 ms wait or polling
// - eeprom byte write followed by 4.0 ms wait or polling
// - load high byte refused unless low byte of same address came first
// - flash page write followed by 4.5 ms wait or polling
// - poll repeats until returned bit zero is clear
// - no link traffic until a write wait or poll has finished
// - end of session releases reset high
`timescale 1ns/10ps
`default_nettype none
`include "sispce_regs.vh"

module sispce_host #(
    parameter [31:0] PWRUP_CYC = `SISPCE_T_PWRUP_US * `SISPCE_CLK_MHZ,
    parameter [31:0] ERASE_CYC = `SISPCE_T_ERASE_US * `SISPCE_CLK_MHZ,
    parameter [31:0] FLASH_CYC = `SISPCE_T_FLASH_US * `SISPCE_CLK_MHZ,
    parameter [31:0] EEPROM_CYC = `SISPCE_T_EEPROM_US * `SISPCE_CLK_MHZ,
    parameter [31:0] FUSE_CYC = `SISPCE_T_FUSE_US * `SISPCE_CLK_MHZ,
    parameter [31:0] RST_PULSE_CYC = (`SISPCE_T_RST_PULSE_NS * `SISPCE_CLK_MHZ + 999) / 1000,
    parameter [31:0] SCK_HALF_CYC = (`SISPCE_T_SCK_HALF_NS * `SISPCE_CLK_MHZ + 999) / 1000,
    parameter [2:0] MAX_RETRY = `SISPCE_MAX_RETRY
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire [`SISPCE_ADDR_W-1:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output wire [31:0] rd_data_o,
    output wire dev_reset_n_o,
    output wire sck_o,
    output wire mosi_o,
    input wire miso_i
);

    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_RSTHI = 3'd1;
    localparam [2:0] S_SETTLE = 3'd2;
    localparam [2:0] S_SHIFT = 3'd3;
    localparam [2:0] S_DONE = 3'd4;
    localparam [2:0] S_WAIT = 3'd5;

    localparam [1:0] K_USER = 2'd0;
    localparam [1:0] K_ENABLE = 2'd1;
    localparam [1:0] K_POLL = 2'd2;

    reg [2:0] st_q;
    reg [1:0] kind_q;
    reg [31:0] tmr_q;
    reg [31:0] wait_q;
    reg [31:0] tx_q;
    reg [31:0] rx_q;
    reg [5:0] bit_q;
    reg phase_q;
    reg [2:0] retry_q;
    reg sess_q;
    reg poll_mode_q;
    reg [31:0] instr_q;
    reg [31:0] resp_q;
    reg fail_q;
    reg refused_q;
    reg done_q;
    reg lo_ok_q;
    reg [15:0] lo_addr_q;
    reg sck_q;
    reg mosi_q;
    reg rstn_q;
    reg [31:0] rdata_q;
    reg miso_m_q;
    reg miso_s_q;

    wire [7:0] op = instr_q[31:24];
    wire [7:0] sub = instr_q[23:16];
    wire busy = (st_q != S_IDLE);
    wire ctrl_wr = wr_i && (addr_i == `SISPCE_OFS_CTRL);
    wire [31:0] half_m1 = SCK_HALF_CYC - 32'd1;

    reg [31:0] wait_sel;
    reg hi_bad;

    assign rd_data_o = rdata_q;
    assign dev_reset_n_o = rstn_q;
    assign sck_o = sck_q;
    assign mosi_o = mosi_q;

    // wait chosen from the opcode about to be sent
    always @* begin
        wait_sel = 32'd0;
        if (op == `SISPCE_OP_AC && sub == `SISPCE_SUB_ERASE) begin
            wait_sel = ERASE_CYC;
        end else if (op == `SISPCE_OP_AC && (sub == `SISPCE_SUB_LOCK || sub == `SISPCE_SUB_FUSE_LO ||
                     sub == `SISPCE_SUB_FUSE_HI || sub == `SISPCE_SUB_FUSE_EXT)) begin
            wait_sel = FUSE_CYC;
        end else if (op == `SISPCE_OP_EE_WR || op == `SISPCE_OP_EE_PAGE_WR) begin
            wait_sel = EEPROM_CYC;
        end else if (op == `SISPCE_OP_PAGE_WR) begin
            wait_sel = FLASH_CYC;
        end
        hi_bad = (op == `SISPCE_OP_LOAD_HI) && !(lo_ok_q && lo_addr_q == instr_q[23:8]);
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            miso_m_q <= miso_i;
            miso_s_q <= miso_m_q;
        end
    end

    // register read port, data valid only in the cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_i) begin
            if (addr_i == `SISPCE_OFS_CTRL) begin
                rdata_q <= {29'd0, poll_mode_q, 2'b00};
            end else if (addr_i == `SISPCE_OFS_INSTR) begin
                rdata_q <= instr_q;
            end else if (addr_i == `SISPCE_OFS_RESP) begin
                rdata_q <= resp_q;
            end else if (addr_i == `SISPCE_OFS_STAT) begin
                rdata_q <= {27'd0, done_q, refused_q, fail_q, sess_q, busy};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= S_IDLE;
            kind_q <= K_USER;
            tmr_q <= 32'd0;
            wait_q <= 32'd0;
            tx_q <= 32'd0;
            rx_q <= 32'd0;
            bit_q <= 6'd0;
            phase_q <= 1'b0;
            retry_q <= 3'd0;
            sess_q <= 1'b0;
            poll_mode_q <= 1'b0;
            instr_q <= 32'd0;
            resp_q <= 32'd0;
            fail_q <= 1'b0;
            refused_q <= 1'b0;
            done_q <= 1'b0;
            lo_ok_q <= 1'b0;
            lo_addr_q <= 16'd0;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            // sticky clears first so a same-cycle set below wins
            if (wr_i && addr_i == `SISPCE_OFS_STAT) begin
                if (wr_data_i[`SISPCE_STAT_FAIL]) fail_q <= 1'b0;
                if (wr_data_i[`SISPCE_STAT_REFUSED]) refused_q <= 1'b0;
                if (wr_data_i[`SISPCE_STAT_DONE]) done_q <= 1'b0;
            end
            if (wr_i && addr_i == `SISPCE_OFS_INSTR && !busy) begin
                instr_q <= wr_data_i;
            end
            if (ctrl_wr) begin
                poll_mode_q <= wr_data_i[`SISPCE_CTRL_POLL];
            end
            case (st_q)
                S_IDLE: begin
                    sck_q <= 1'b0;
                    if (ctrl_wr && wr_data_i[`SISPCE_CTRL_END]) begin
                        rstn_q <= 1'b1;
                        sess_q <= 1'b0;
                        lo_ok_q <= 1'b0;
                    end else if (ctrl_wr && wr_data_i[`SISPCE_CTRL_START]) begin
                        sess_q <= 1'b0;
                        retry_q <= 3'd0;
                        rstn_q <= 1'b1;
                        tmr_q <= RST_PULSE_CYC - 32'd1;
                        st_q <= S_RSTHI;
                    end else if (ctrl_wr && wr_data_i[`SISPCE_CTRL_GO]) begin
                        if (!sess_q || rstn_q || hi_bad) begin
                            refused_q <= 1'b1;
                        end else begin
                            if (op == `SISPCE_OP_LOAD_LO) begin
                                lo_ok_q <= 1'b1;
                                lo_addr_q <= instr_q[23:8];
                            end else if (op == `SISPCE_OP_LOAD_HI) begin
                                lo_ok_q <= 1'b0;
                            end
                            wait_q <= wait_sel;
                            kind_q <= K_USER;
                            tx_q <= instr_q;
                            mosi_q <= instr_q[31];
                            bit_q <= 6'd0;
                            phase_q <= 1'b0;
                            tmr_q <= half_m1;
                            st_q <= S_SHIFT;
                        end
                    end
                end
                S_RSTHI: begin
                    if (tmr_q != 32'd0) begin
                        tmr_q <= tmr_q - 32'd1;
                    end else begin
                        rstn_q <= 1'b0;
                        tmr_q <= PWRUP_CYC - 32'd1;
                        st_q <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (tmr_q != 32'd0) begin
                        tmr_q <= tmr_q - 32'd1;
                    end else begin
                        kind_q <= K_ENABLE;
                        tx_q <= `SISPCE_INSTR_ENABLE;
                        mosi_q <= 1'b1;
                        bit_q <= 6'd0;
                        phase_q <= 1'b0;
                        tmr_q <= half_m1;
                        st_q <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (tmr_q != 32'd0) begin
                        tmr_q <= tmr_q - 32'd1;
                    end else if (!phase_q) begin
                        sck_q <= 1'b1;
                        rx_q <= {rx_q[30:0], miso_s_q};
                        phase_q <= 1'b1;
                        tmr_q <= half_m1;
                    end else begin
                        sck_q <= 1'b0;
                        phase_q <= 1'b0;
                        tmr_q <= half_m1;
                        if (bit_q == 6'd31) begin
                            mosi_q <= 1'b0;
                            st_q <= S_DONE;
                        end else begin
                            bit_q <= bit_q + 6'd1;
                            tx_q <= {tx_q[30:0], 1'b0};
                            mosi_q <= tx_q[30];
                        end
                    end
                end
                S_DONE: begin
                    if (kind_q == K_ENABLE) begin
                        if (rx_q[15:8] == `SISPCE_ECHO) begin
                            sess_q <= 1'b1;
                            done_q <= 1'b1;
                            st_q <= S_IDLE;
                        end else if (retry_q < MAX_RETRY) begin
                            retry_q <= retry_q + 3'd1;
                            rstn_q <= 1'b1;
                            tmr_q <= RST_PULSE_CYC - 32'd1;
                            st_q <= S_RSTHI;
                        end else begin
                            fail_q <= 1'b1;
                            st_q <= S_IDLE;
                        end
                    end else if (kind_q == K_POLL) begin
                        if (rx_q[0]) begin
                            tx_q <= `SISPCE_INSTR_POLL;
                            mosi_q <= 1'b1;
                            bit_q <= 6'd0;
                            tmr_q <= half_m1;
                            st_q <= S_SHIFT;
                        end else begin
                            done_q <= 1'b1;
                            st_q <= S_IDLE;
                        end
                    end else begin
                        resp_q <= rx_q;
                        if (wait_q == 32'd0) begin
                            done_q <= 1'b1;
                            st_q <= S_IDLE;
                        end else if (poll_mode_q) begin
                            kind_q <= K_POLL;
                            tx_q <= `SISPCE_INSTR_POLL;
                            mosi_q <= 1'b1;
                            bit_q <= 6'd0;
                            tmr_q <= half_m1;
                            st_q <= S_SHIFT;
                        end else begin
                            tmr_q <= wait_q - 32'd1;
                            st_q <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (tmr_q != 32'd0) begin
                        tmr_q <= tmr_q - 32'd1;
                    end else begin
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- sispce_host_properties.sv ----
// concurrent checks on the isp host link pins
`timescale 1ns/10ps
`default_nettype none
module sispce_properties (
    input wire clk_i,
    input wire reset_n_i,
    input wire dev_reset_n_o,
    input wire sck_o,
    input wire mosi_o
);
    logic [7:0] low_q;
    logic [7:0] bits_q;
    // low run length and sck rises since last reset pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_q <= 8'h00;
            bits_q <= 8'h00;
        end else begin
            if (sck_o) low_q <= 8'h00;
            else if (low_q != 8'hff) low_q <= low_q + 8'h01;
            if (dev_reset_n_o) bits_q <= 8'h00;
            else if (sck_o && low_q != 8'h00) bits_q <= bits_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    link_in_reset_a: assert property (sck_o |-> !dev_reset_n_o)
        else $error("sck toggles with device out of reset");
    mosi_hold_high_a: assert property (sck_o |-> $stable(mosi_o))
        else $error("mosi moved while sck high");
    sck_high_len_a: assert property ($rose(sck_o) |-> sck_o [*4] ##1 !sck_o)
        else $error("sck high phase length wrong");
    sck_low_len_a: assert property ($fell(sck_o) |-> !sck_o [*4])
        else $error("sck low phase too short");
    rst_pulse_len_a: assert property ($rose(dev_reset_n_o) |-> dev_reset_n_o [*4])
        else $error("reset pulse too short");
    sck_low_pulse_a: assert property ($rose(dev_reset_n_o) |-> !sck_o && !$past(sck_o))
        else $error("reset pulse without sck low");
    pwrup_quiet_a: assert property ($fell(dev_reset_n_o) |-> (!sck_o throughout ##199 1'b1))
        else $error("link traffic before power-up wait");
    frame_whole_a: assert property (low_q == 8'h0c |-> bits_q[4:0] == 5'h00)
        else $error("instruction not a whole four bytes");
    cover property ($rose(sck_o));
    cover property ($fell(dev_reset_n_o));
    cover property (low_q == 8'h0c && bits_q > 8'h20);
endmodule
bind sispce_host sispce_properties sispce_properties_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .dev_reset_n_o(dev_reset_n_o), .sck_o(sck_o), .mosi_o(mosi_o));
`default_nettype wire

// ---- sispce_dev_model.sv ----
// behavioural target device answering the isp host
`timescale 1ns/10ps
`default_nettype none
module sispce_dev_model (
    input wire logic clk_i,
    input wire logic rst_pin_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o
);
    int drops = 0, busy = 0, busy_len = 90, n = 0, i;
    bit en = 0;
    logic [31:0] rx = 32'h0000_0000;
    logic [7:0] ob = 8'h00, fuse = 8'h62, lock = 8'hff;
    logic [15:0] fl [64];
    logic [15:0] pb [32];
    logic [7:0] ee [64];
    logic [8:0] eb [4];
    logic [7:0] fuse_live = 8'h62;
    initial miso_o = 1'b0;
    // unloaded page buffer words read back as erased
    initial begin
        for (int j = 0; j < 32; j++) pb[j] = 16'hffff;
        for (int j = 0; j < 4; j++) eb[j] = 9'h0ff;
    end
    function automatic logic [7:0] rdval(input logic [23:0] h);
        case (h[23:16])
            8'h20: return fl[h[5:0]][7:0];
            8'h28: return fl[h[5:0]][15:8];
            8'hA0: return ee[h[5:0]];
            8'h50: return fuse;
            8'h58: return lock;
            8'hF0: return {7'h00, busy != 0};
            default: return ~ob;
        endcase
    endfunction
    task automatic exec(input logic [31:0] c);
        if (!en) begin
            if (c[31:16] == 16'hAC53 && drops > 0) drops--;
            else if (c[31:16] == 16'hAC53) begin
                en = 1;
                fuse_live = fuse;
            end
        end else if (busy == 0 || c[31:24] == 8'hF0) begin
            case (c[31:24])
                8'h40: pb[c[12:8]][7:0] = c[7:0];
                8'h48: pb[c[12:8]][15:8] = c[7:0];
                8'h4C: begin
                    for (i = 0; i < 32; i++) fl[{c[13], i[4:0]}] = pb[i];
                    busy = busy_len;
                end
                8'hC1: eb[c[9:8]] = {1'b1, c[7:0]};
                8'hC2: begin
                    for (i = 0; i < 4; i++) if (eb[i][8]) ee[{c[13:10], i[1:0]}] = eb[i][7:0];
                    for (i = 0; i < 4; i++) eb[i] = 9'h0ff;
                    busy = busy_len;
                end
                8'hC0: begin
                    ee[c[13:8]] = c[7:0];
                    busy = busy_len;
                end
                8'hAC: begin
                    if (c[23:16] == 8'h80) begin
                        for (i = 0; i < 64; i++) fl[i] = 16'hffff;
                        for (i = 0; i < 64; i++) ee[i] = 8'hff;
                        lock = 8'hff;
                    end
                    if (c[23:16] == 8'hE0) lock = c[7:0];
                    if (c[23:16] == 8'hA0 && lock[0]) fuse = c[7:0];
                    busy = busy_len;
                end
                default: ;
            endcase
        end
    endtask
    always @(posedge sck_i) begin
        if (!rst_pin_i) begin
            rx = {rx[30:0], mosi_i};
            n = n + 1;
            if (n == 16) ob = drops > 0 ? ~rx[7:0] : rx[7:0];
            if (n == 24) ob = rdval(rx[23:0]);
            if (n == 32) exec(rx);
            if (n == 32) n = 0;
        end
    end
    // unread bits toggle so stale data never looks valid
    always @(negedge sck_i) begin
        miso_o <= ob[7];
        ob = {ob[6:0], ~ob[7]};
    end
    always @(posedge rst_pin_i) begin
        en = 0;
        n = 0;
    end
    always @(posedge clk_i) if (busy > 0) busy = busy - 1;
endmodule
`default_nettype wire

// ---- sispce_tb.sv ----
// self-checking bench for the isp host against the device model
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wr_data_i = 32'h0000_0000, v, pm = 32'h0000_0000;
    wire [31:0] rd_data_o;
    wire miso, sck, mosi, drst_n;
    int mismatches = 0, samples_checked = 0, seed = 17, k, a, d, e;
    int ref_fl [64];
    sispce_host #(.PWRUP_CYC(200), .ERASE_CYC(100), .EEPROM_CYC(100),
        .RST_PULSE_CYC(4), .SCK_HALF_CYC(4)) sispce_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .dev_reset_n_o(drst_n), .sck_o(sck), .mosi_o(mosi), .miso_i(miso));
    sispce_dev_model sispce_dev_model_i (.clk_i(clk_i), .rst_pin_i(drst_n), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) mismatches++;
        if (s !== e) $display("unexpected at %0t: saw %h want %h", $time, s, e);
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        addr_i <= ad;
        wr_data_i <= dt;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [31:0] dt);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 dt = rd_data_o;
    endtask
    task automatic idle();
        repeat (3) @(posedge clk_i);
        for (k = 0; k < 3000 && v[0] !== 1'b0; k++) rd(4'h3, v);
        chk(v[0], 1'b0);
    endtask
    task automatic send(input logic [31:0] ins);
        wr(4'h1, ins);
        wr(4'h0, pm | 32'h0000_0008);
        v = 32'h0000_0001;
        idle();
        rd(4'h2, v);
    endtask
    task automatic start(input int n_drop);
        sispce_dev_model_i.drops = n_drop;
        wr(4'h3, 32'h0000_001C);
        wr(4'h0, 32'h0000_0001);
        v = 32'h0000_0001;
        idle();
        rd(4'h3, v);
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        send(32'h2000_0000);
        rd(4'h3, v);
        chk(v[3], 1'b1);
        chk(drst_n, 1'b0);
        rd(4'h7, v);
        chk(v, 32'h0000_0000);
        start(5);
        chk(v[4:1], 4'b0010);
        start(1);
        chk(v[4:1], 4'b1001);
        $display("session tests done");
        send(32'hAC80_0000);
        for (k = 0; k < 64; k++) ref_fl[k] = 16'hffff;
        a = $random(seed) & 63;
        send(32'h2000_0000 | (a << 8));
        chk(v[7:0], 8'hff);
        for (d = 0; d < 3; d++) begin
            a = 32 + ($random(seed) & 31);
            ref_fl[a] = $random(seed) & 16'hffff;
            send(32'h4000_0000 | (a << 8) | (ref_fl[a] & 255));
            send(32'h4800_0000 | (a << 8) | (ref_fl[a] >> 8));
        end
        sispce_dev_model_i.busy_len = 400;
        pm = 32'h0000_0004;
        send(32'h4C00_2000);
        rd(4'h0, v);
        chk(v, 32'h0000_0004);
        rd(4'h1, v);
        chk(v, 32'h4C00_2000);
        pm = 32'h0000_0000;
        sispce_dev_model_i.busy_len = 90;
        for (a = 32; a < 64; a++) begin
            send(32'h2000_0000 | (a << 8));
            chk(v[7:0], ref_fl[a] & 255);
            send(32'h2800_0000 | (a << 8));
            chk(v[7:0], ref_fl[a] >> 8);
        end
        wr(4'h3, 32'h0000_001C);
        send(32'h4800_0700);
        rd(4'h3, v);
        chk(v[3], 1'b1);
        $display("flash tests done");
        a = $random(seed) & 63;
        d = $random(seed) & 255;
        send(32'hC000_0000 | (a << 8) | d);
        send(32'h1234_5678);
        send(32'h4D00_0100);
        send(32'hA000_0000 | (a << 8));
        chk(v[7:0], d);
        e = $random(seed) & 255;
        send(32'hC100_0000 | (((a ^ 1) & 3) << 8) | e);
        send(32'hC200_0000 | ((a & 60) << 8));
        send(32'hA000_0000 | ((a ^ 1) << 8));
        chk(v[7:0], e);
        send(32'hA000_0000 | (a << 8));
        chk(v[7:0], d);
        pm = 32'h0000_0004;
        send(32'hACA0_0033);
        send(32'h5000_0000);
        chk(v[7:0], 8'h33);
        send(32'hACE0_00FE);
        send(32'hACA0_0055);
        send(32'h5000_0000);
        chk(v[7:0], 8'h33);
        send(32'h5800_0000);
        chk(v[7:0], 8'hfe);
        wr(4'h0, 32'h0000_0002);
        rd(4'h3, v);
        chk(v[1], 1'b0);
        chk(drst_n, 1'b1);
        $display("memory tests done");
        close_out();
    end
endmodule
`default_nettype wire
